// *** shared/fault_regs_pkg.sv ***
package fault_regs_pkg;
   localparam int CLK_FREQ_MHZ          = 200;
   localparam int INPUT_OVERLOAD_US     = 200;
   localparam int SWITCH_RESTORE_US     = 20;
   localparam int SWITCH_RESTORE_CYCLES = SWITCH_RESTORE_US * CLK_FREQ_MHZ;
   localparam int RESTORE_W             = 13;
   localparam int PIN_COUNT             = 7;
   localparam int PIN_CAL               = 2;
   localparam int PIN_FAULT             = 3;

   localparam logic [6:0] ADDR_IF_FLAGS = 7'h03;
   localparam logic [6:0] ADDR_AN_FLAGS = 7'h04;
   localparam logic [6:0] ADDR_PIN_DATA = 7'h05;
   localparam logic [6:0] ADDR_SW_SEL   = 7'h06;
   localparam logic [6:0] ADDR_WB_CTRL  = 7'h07;
   localparam logic [6:0] ADDR_PIN_DIR  = 7'h08;
   localparam logic [6:0] ADDR_AN_MASK  = 7'h0a;
   localparam logic [6:0] ADDR_SPECIAL_FUNCTION_CONFIG   = 7'h0c;

   localparam int IF_CAL_BUSY_BIT = 6;
   localparam int IF_CRC_BIT      = 5;
   localparam int IF_ACCESS_BIT   = 4;
   localparam int IF_COUNT_BIT    = 3;
   localparam int IF_MAP_BIT      = 1;
   localparam int IF_ROM_BIT      = 0;
   localparam int AN_GAIN_BIT     = 7;
   localparam int AN_HV_BIT       = 6;
   localparam int AN_WB_BIT       = 4;
   localparam int AN_FAULT_BIT    = 3;
   localparam int AN_OUT_BIT      = 2;
   localparam int AN_IN_BIT       = 1;
   localparam int AN_OV_BIT       = 0;
   localparam int WB_F1_BIT       = 3;
   localparam int WB_F2_BIT       = 2;
   localparam int SF_FAULT_OUT_BIT = 0;
   localparam int SF_CAL_OUT_BIT   = 1;

   localparam logic [7:0] IF_ERR_MASK = 8'h3b;
   localparam logic [7:0] AN_ERR_MASK = 8'hd7;
   localparam logic [7:0] AN_W1C_MASK = 8'hdf;
   localparam logic [7:0] AN_MASK_RW  = 8'hdf;
   localparam logic [7:0] WB_RW_MASK  = 8'h8f;
   localparam logic [7:0] SF_RW_MASK  = 8'h03;
   localparam logic [6:0] SW_RST      = 7'h60;
   localparam logic [7:0] WB_RST      = 8'h02;

   localparam int         FRAME_BITS  = 24;
   localparam int         HEADER_BITS = 8;
   localparam int         DATA_END    = 16;
   localparam int         CNT_W       = 6;
   localparam logic [7:0] CRC_POLY    = 8'h07;
endpackage : fault_regs_pkg

// *** shared/reg_access_if.sv ***
`timescale 1ns/1ps
interface reg_access_if;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       crc_err;
   logic       cnt_err;

   modport engine (output addr, output wdata, output wr, output rd, input rdata,
                   output crc_err, output cnt_err);
   modport regs   (input addr, input wdata, input wr, input rd, output rdata,
                   input crc_err, input cnt_err);
endinterface : reg_access_if

// *** rtl/serial_frame_engine.sv ***
`timescale 1ns/1ps
module serial_frame_engine
   import fault_regs_pkg::*;
(
   input  wire logic   REF_CLK,
   input  wire logic   RST_N,
   input  wire logic   CS_N,
   input  wire logic   SCLK,
   input  wire logic   MOSI,
   output logic        MISO,
   reg_access_if.engine ra
);
   typedef struct packed {
      logic                  sclk_q;
      logic                  cs_q;
      logic [CNT_W-1:0]      cnt;
      logic [FRAME_BITS-1:0] sh;
      logic [7:0]            crc;
      logic [7:0]            tx;
      logic                  miso;
      logic [6:0]            addr;
      logic                  rw;
      logic [7:0]            wdata;
      logic                  wr;
      logic                  rd;
      logic                  crc_err;
      logic                  cnt_err;
   } eng_t;

   eng_t s_r;
   eng_t s_nxt;
   logic rise;
   logic fall;

   assign rise = !CS_N && !s_r.sclk_q && SCLK;
   assign fall = !CS_N && s_r.sclk_q && !SCLK;

   always_comb begin
      s_nxt         = s_r;
      s_nxt.sclk_q  = SCLK;
      s_nxt.cs_q    = CS_N;
      s_nxt.wr      = 1'b0;
      s_nxt.rd      = 1'b0;
      s_nxt.crc_err = 1'b0;
      s_nxt.cnt_err = 1'b0;
      if (s_r.rd) begin
         s_nxt.tx = ra.rdata;
      end
      if (s_r.cs_q && !CS_N) begin
         s_nxt.cnt = '0;
         s_nxt.crc = '0;
      end else if (rise) begin
         s_nxt.sh = {s_r.sh[FRAME_BITS-2:0], MOSI};
         if (s_r.cnt != {CNT_W{1'b1}}) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
         end
         if (s_r.cnt < CNT_W'(DATA_END)) begin
            s_nxt.crc = {s_r.crc[6:0], 1'b0} ^ ((s_r.crc[7] ^ MOSI) ? CRC_POLY : 8'h00);
         end
         if (s_r.cnt == CNT_W'(HEADER_BITS - 1)) begin
            s_nxt.rw   = s_nxt.sh[7];
            s_nxt.addr = s_nxt.sh[6:0];
            s_nxt.rd   = s_nxt.sh[7];
         end
      end else if (fall) begin
         // Read data leaves MSB first on the falling edges of the data byte
         if (s_r.cnt >= CNT_W'(HEADER_BITS) && s_r.cnt < CNT_W'(DATA_END)) begin
            s_nxt.miso = s_r.tx[7];
            s_nxt.tx   = {s_r.tx[6:0], 1'b0};
         end
      end else if (!s_r.cs_q && CS_N) begin
         s_nxt.miso = 1'b0;
         if (s_r.cnt != CNT_W'(FRAME_BITS)) begin
            s_nxt.cnt_err = 1'b1;
         end else if (s_r.sh[7:0] != s_r.crc) begin
            s_nxt.crc_err = 1'b1;
         end else if (!s_r.rw) begin
            s_nxt.wr    = 1'b1;
            s_nxt.wdata = s_r.sh[15:8];
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_r        <= '0;
         s_r.sclk_q <= 1'b0;
         s_r.cs_q   <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign MISO       = s_r.miso;
   assign ra.addr    = s_r.addr;
   assign ra.wdata   = s_r.wdata;
   assign ra.wr      = s_r.wr;
   assign ra.rd      = s_r.rd;
   assign ra.crc_err = s_r.crc_err;
   assign ra.cnt_err = s_r.cnt_err;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   a_short_frame: assert property (
      (!s_r.cs_q && CS_N && s_r.cnt != CNT_W'(FRAME_BITS)) |=> ra.cnt_err && !ra.wr)
      else $error("bad edge count not reported");
   a_bad_check: assert property (
      ra.crc_err |-> !ra.wr && !ra.cnt_err)
      else $error("write taken despite checksum error");
endmodule : serial_frame_engine

// *** rtl/fault_flags_and_port_regs.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Busy flag follows calibration; writes ignored
// - Busy flag on pin two when enabled
// - Checksum mismatch on transfer sets flag
// - Invalid register address sets access flag
// - Wrong clock edge count sets flag
// - Map checksum mismatch sets flag
// - Failed memory check sets flag
// - Forced gain default sets gain flag
// - Clearing gain flag restores nothing
// - Supply trip sets flag, recovery calibrates
// - Wire break during test sets flag
// - Fault is OR of unmasked flags
// - Fault low on pin three when enabled
// - Output overload sets flag
// - Input overload flag; long overload forces gain
// - Overvoltage opens switches, readback unchanged
// - Switches restored after quiet restore time
// - Latched keeps flag; nonlatched clears on restore
// - Writing one clears a flag
// - Output pins follow data bits
// - Input pins read level, writes ignored
// - Mask bit removes analog flag from fault
// - Direction one means output
module fault_flags_and_port_regs
   import fault_regs_pkg::*;
#(
   parameter int INPUT_HOLD_CYCLES = INPUT_OVERLOAD_US * CLK_FREQ_MHZ,
   parameter int HOLD_W            = 20
)(
   input  wire logic                 REF_CLK,
   input  wire logic                 RST_N,
   input  wire logic                 CS_N,
   input  wire logic                 SCLK,
   input  wire logic                 MOSI,
   output logic                      MISO,
   input  wire logic [PIN_COUNT-1:0] PIN_IN,
   output logic      [PIN_COUNT-1:0] PIN_OUT,
   output logic      [PIN_COUNT-1:0] PIN_OE,
   input  wire logic                 CAL_ACTIVE,
   input  wire logic                 ROM_CHECK_FAIL,
   input  wire logic                 HV_SUPPLY_TRIP,
   input  wire logic                 WIRE_BREAK_SENSE,
   input  wire logic                 OUTPUT_OVERLOAD,
   input  wire logic                 INPUT_OVERLOAD,
   input  wire logic                 SWITCH_OVERVOLT,
   input  wire logic                 LATCHED_MODE,
   output logic      [6:0]           SWITCH_DRIVE,
   output logic      [7:0]           WB_CONTROL,
   output logic                      GAIN_DEFAULT_LOAD,
   output logic                      CAL_START
);
   if (INPUT_HOLD_CYCLES < 1 || INPUT_HOLD_CYCLES >= (1 << HOLD_W)) begin : g_bad_hold
      $error("INPUT_HOLD_CYCLES does not fit the hold counter");
   end
   if (SWITCH_RESTORE_CYCLES >= (1 << RESTORE_W)) begin : g_bad_restore
      $error("restore count does not fit its counter");
   end

   localparam logic [HOLD_W-1:0]    HOLD_LAST    = HOLD_W'(INPUT_HOLD_CYCLES - 1);
   localparam logic [HOLD_W-1:0]    HOLD_TOP     = HOLD_W'(INPUT_HOLD_CYCLES);
   localparam logic [RESTORE_W-1:0] RESTORE_LAST = RESTORE_W'(SWITCH_RESTORE_CYCLES - 1);
   localparam logic [RESTORE_W-1:0] RESTORE_TOP  = RESTORE_W'(SWITCH_RESTORE_CYCLES);

   typedef struct packed {
      logic [7:0]           if_flags;
      logic [7:0]           an_flags;
      logic [6:0]           pin_data;
      logic [6:0]           sw_prog;
      logic [7:0]           wb_ctrl;
      logic [6:0]           pin_dir;
      logic [7:0]           an_mask;
      logic [7:0]           special_function_config;
      logic [7:0]           map_sum;
      logic [HOLD_W-1:0]    in_cnt;
      logic [RESTORE_W-1:0] ov_cnt;
      logic                 sw_open;
      logic                 hv_trip_q;
      logic                 gain_load;
      logic                 cal_start;
      logic [6:0]           pin_out;
      logic [6:0]           pin_oe;
      logic [6:0]           sw_drive;
   } regs_t;

   function automatic logic [7:0] map_check(input logic [6:0] pd, input logic [6:0] sw,
                                            input logic [7:0] wb, input logic [6:0] dir,
                                            input logic [7:0] msk, input logic [7:0] sf);
      map_check = {1'b0, pd} ^ {1'b0, sw} ^ wb ^ {1'b0, dir} ^ msk ^ sf;
   endfunction : map_check

   function automatic logic addr_valid(input logic [6:0] a);
      addr_valid = (a == ADDR_IF_FLAGS) || (a == ADDR_AN_FLAGS) || (a == ADDR_PIN_DATA) ||
                   (a == ADDR_SW_SEL) || (a == ADDR_WB_CTRL) || (a == ADDR_PIN_DIR) ||
                   (a == ADDR_AN_MASK) || (a == ADDR_SPECIAL_FUNCTION_CONFIG);
   endfunction : addr_valid

   localparam regs_t REGS_RST = '{
      if_flags: 8'h00, an_flags: 8'h00, pin_data: 7'h00, sw_prog: SW_RST,
      wb_ctrl: WB_RST, pin_dir: 7'h00, an_mask: 8'h00, special_function_config: 8'h00,
      map_sum: map_check(7'h00, SW_RST, WB_RST, 7'h00, 8'h00, 8'h00),
      in_cnt: '0, ov_cnt: '0, sw_open: 1'b0, hv_trip_q: 1'b0, gain_load: 1'b0,
      cal_start: 1'b0, pin_out: 7'h00, pin_oe: 7'h00, sw_drive: SW_RST};

   reg_access_if ra ();

   serial_frame_engine u_engine (
      .REF_CLK (REF_CLK),
      .RST_N   (RST_N),
      .CS_N    (CS_N),
      .SCLK    (SCLK),
      .MOSI    (MOSI),
      .MISO    (MISO),
      .ra      (ra)
   );

   regs_t      s_r;
   regs_t      s_nxt;
   logic [7:0] if_view;
   logic [7:0] if_set;
   logic [7:0] if_clr;
   logic [7:0] an_set;
   logic [7:0] an_clr;
   logic       fault_raw;
   logic       wb_test;
   logic       bad_access;
   logic [6:0] pin_view;
   logic [6:0] pin_drv;

   // Busy bit is live, never stored, so no write can reach it
   assign if_view  = (s_r.if_flags & IF_ERR_MASK) | (8'(CAL_ACTIVE) << IF_CAL_BUSY_BIT);
   assign pin_view = (s_r.pin_data & s_r.pin_dir) | (PIN_IN & ~s_r.pin_dir);
   assign wb_test  = s_r.wb_ctrl[WB_F1_BIT] || s_r.wb_ctrl[WB_F2_BIT];
   assign bad_access = (ra.wr || ra.rd) && !addr_valid(ra.addr);
   assign fault_raw = |(s_r.if_flags & IF_ERR_MASK) |
                      |(s_r.an_flags & AN_ERR_MASK & ~s_r.an_mask);

   always_comb begin
      case (ra.addr)
         ADDR_IF_FLAGS: ra.rdata = if_view;
         ADDR_AN_FLAGS: ra.rdata = s_r.an_flags & AN_W1C_MASK;
         ADDR_PIN_DATA: ra.rdata = {1'b0, pin_view};
         // Readback shows the programmed switches, not the forced-open state
         ADDR_SW_SEL:   ra.rdata = {1'b0, s_r.sw_prog};
         ADDR_WB_CTRL:  ra.rdata = s_r.wb_ctrl;
         ADDR_PIN_DIR:  ra.rdata = {1'b0, s_r.pin_dir};
         ADDR_AN_MASK:  ra.rdata = s_r.an_mask;
         ADDR_SPECIAL_FUNCTION_CONFIG:   ra.rdata = s_r.special_function_config;
         default:       ra.rdata = 8'h00;
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      if_set = 8'h00;
      if_clr = 8'h00;
      an_set = 8'h00;
      an_clr = 8'h00;
      pin_drv = 7'h00;
      s_nxt.gain_load = 1'b0;
      s_nxt.cal_start = 1'b0;
      s_nxt.hv_trip_q = HV_SUPPLY_TRIP;

      if (ra.wr) begin
         case (ra.addr)
            ADDR_IF_FLAGS: if_clr = ra.wdata & IF_ERR_MASK;
            ADDR_AN_FLAGS: an_clr = ra.wdata & AN_W1C_MASK;
            ADDR_PIN_DATA: s_nxt.pin_data = (ra.wdata[6:0] & s_r.pin_dir) |
                                            (s_r.pin_data & ~s_r.pin_dir);
            ADDR_SW_SEL:   s_nxt.sw_prog = ra.wdata[6:0];
            ADDR_WB_CTRL:  s_nxt.wb_ctrl = ra.wdata & WB_RW_MASK;
            ADDR_PIN_DIR:  s_nxt.pin_dir = ra.wdata[6:0];
            ADDR_AN_MASK:  s_nxt.an_mask = ra.wdata & AN_MASK_RW;
            ADDR_SPECIAL_FUNCTION_CONFIG:   s_nxt.special_function_config = ra.wdata & SF_RW_MASK;
            default:       s_nxt.map_sum = s_r.map_sum;
         endcase
         s_nxt.map_sum = map_check(s_nxt.pin_data, s_nxt.sw_prog, s_nxt.wb_ctrl,
                                   s_nxt.pin_dir, s_nxt.an_mask, s_nxt.special_function_config);
      end

      if_set[IF_CRC_BIT]    = ra.crc_err;
      if_set[IF_ACCESS_BIT] = bad_access;
      if_set[IF_COUNT_BIT]  = ra.cnt_err;
      // Stored map checked against the sum taken at the last write
      if_set[IF_MAP_BIT]    = map_check(s_r.pin_data, s_r.sw_prog, s_r.wb_ctrl, s_r.pin_dir,
                                        s_r.an_mask, s_r.special_function_config) != s_r.map_sum;
      if_set[IF_ROM_BIT]    = ROM_CHECK_FAIL;

      an_set[AN_HV_BIT]  = HV_SUPPLY_TRIP;
      s_nxt.cal_start    = s_r.hv_trip_q && !HV_SUPPLY_TRIP;
      an_set[AN_WB_BIT]  = wb_test && WIRE_BREAK_SENSE;
      an_set[AN_OUT_BIT] = OUTPUT_OVERLOAD;
      an_set[AN_IN_BIT]  = INPUT_OVERLOAD;
      an_set[AN_FAULT_BIT] = fault_raw;

      // Counter saturates at the hold time so one episode forces gain only once
      if (!INPUT_OVERLOAD) begin
         s_nxt.in_cnt = '0;
      end else if (s_r.in_cnt != HOLD_TOP) begin
         s_nxt.in_cnt = s_r.in_cnt + 1'b1;
      end
      if (INPUT_OVERLOAD && s_r.in_cnt == HOLD_LAST) begin
         s_nxt.gain_load     = 1'b1;
         an_set[AN_GAIN_BIT] = 1'b1;
      end

      if (SWITCH_OVERVOLT) begin
         s_nxt.sw_open   = 1'b1;
         s_nxt.ov_cnt    = '0;
         an_set[AN_OV_BIT] = 1'b1;
      end else if (s_r.sw_open) begin
         s_nxt.ov_cnt = s_r.ov_cnt + 1'b1;
         if (s_r.ov_cnt == RESTORE_LAST) begin
            s_nxt.sw_open = 1'b0;
            if (!LATCHED_MODE) begin
               an_clr[AN_OV_BIT] = 1'b1;
            end
         end
      end

      // Set wins over a clear landing in the same cycle
      s_nxt.if_flags = ((s_r.if_flags & ~if_clr) | if_set) & IF_ERR_MASK;
      s_nxt.an_flags = ((s_r.an_flags & ~an_clr) | an_set) & AN_W1C_MASK;

      s_nxt.sw_drive = s_nxt.sw_open ? 7'h00 : s_nxt.sw_prog;

      pin_drv = s_nxt.pin_data;
      if (s_nxt.special_function_config[SF_CAL_OUT_BIT]) begin
         pin_drv[PIN_CAL] = CAL_ACTIVE;
      end
      if (s_nxt.special_function_config[SF_FAULT_OUT_BIT]) begin
         pin_drv[PIN_FAULT] = !s_nxt.an_flags[AN_FAULT_BIT];
      end
      s_nxt.pin_oe  = s_nxt.pin_dir;
      s_nxt.pin_out = pin_drv & s_nxt.pin_dir;
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_r <= REGS_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign PIN_OUT           = s_r.pin_out;
   assign PIN_OE            = s_r.pin_oe;
   assign SWITCH_DRIVE      = s_r.sw_drive;
   assign WB_CONTROL        = s_r.wb_ctrl;
   assign GAIN_DEFAULT_LOAD = s_r.gain_load;
   assign CAL_START         = s_r.cal_start;

   // Assertion helper: cycles since overvoltage last stood high, saturating
   logic [RESTORE_W-1:0] quiet_r;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         quiet_r <= '0;
      end else if (SWITCH_OVERVOLT) begin
         quiet_r <= '0;
      end else if (quiet_r != RESTORE_TOP) begin
         quiet_r <= quiet_r + 1'b1;
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   sequence s_quiet_restore;
      s_r.sw_open && !SWITCH_OVERVOLT && s_r.ov_cnt == RESTORE_LAST;
   endsequence

   sequence s_overload_done;
      INPUT_OVERLOAD && s_r.in_cnt == HOLD_LAST;
   endsequence

   a_busy_readback: assert property (
      (ra.addr == ADDR_IF_FLAGS) |-> ra.rdata[IF_CAL_BUSY_BIT] == CAL_ACTIVE)
      else $error("busy bit does not follow calibration");
   a_busy_pin: assert property (
      (s_r.pin_dir[PIN_CAL] && s_r.special_function_config[SF_CAL_OUT_BIT]) |-> PIN_OUT[PIN_CAL] == $past(CAL_ACTIVE))
      else $error("busy flag not on pin two");
   a_crc_flag: assert property (
      ra.crc_err |=> s_r.if_flags[IF_CRC_BIT])
      else $error("checksum flag not set");
   a_access_flag: assert property (
      bad_access |=> s_r.if_flags[IF_ACCESS_BIT] ##1 s_r.an_flags[AN_FAULT_BIT])
      else $error("access flag or fault not raised");
   a_count_flag: assert property (
      ra.cnt_err |=> s_r.if_flags[IF_COUNT_BIT])
      else $error("edge count flag not set");
   a_gain_force: assert property (
      s_overload_done |=> GAIN_DEFAULT_LOAD && s_r.an_flags[AN_GAIN_BIT] ##1 !GAIN_DEFAULT_LOAD)
      else $error("long overload did not force gain once");
   a_gain_cause: assert property (
      GAIN_DEFAULT_LOAD |-> $past(INPUT_OVERLOAD) && s_r.in_cnt == HOLD_TOP)
      else $error("gain forced without long overload");
   a_cal_after_hv: assert property (
      $fell(HV_SUPPLY_TRIP) |=> CAL_START && s_r.an_flags[AN_HV_BIT])
      else $error("no calibration after supply recovery");
   a_fault_or: assert property (
      fault_raw |=> s_r.an_flags[AN_FAULT_BIT])
      else $error("fault not raised for unmasked flag");
   a_fault_pin: assert property (
      (s_r.pin_dir[PIN_FAULT] && s_r.special_function_config[SF_FAULT_OUT_BIT])
         |-> PIN_OUT[PIN_FAULT] == !s_r.an_flags[AN_FAULT_BIT])
      else $error("fault pin not active low");
   a_switch_open: assert property (
      SWITCH_OVERVOLT |=> SWITCH_DRIVE == 7'h00 && s_r.an_flags[AN_OV_BIT])
      else $error("switches not opened on overvoltage");
   a_switch_back: assert property (
      s_quiet_restore |=> SWITCH_DRIVE == $past(s_nxt.sw_prog) &&
                          (s_r.an_flags[AN_OV_BIT] == $past(LATCHED_MODE) || $past(an_set[AN_OV_BIT])))
      else $error("switch restore or flag handling wrong");
   a_restore_bound: assert property (
      (quiet_r == RESTORE_TOP) |-> !s_r.sw_open)
      else $error("switches stayed open too long");
   a_w1c_out: assert property (
      (ra.wr && ra.addr == ADDR_AN_FLAGS && ra.wdata[AN_OUT_BIT] && !OUTPUT_OVERLOAD)
         |=> !s_r.an_flags[AN_OUT_BIT])
      else $error("write one did not clear flag");
   a_pin_out: assert property (
      PIN_OE == s_r.pin_dir && (s_r.special_function_config != 8'h00 || PIN_OUT == (s_r.pin_data & s_r.pin_dir)))
      else $error("output pin does not follow data");
   a_pin_input: assert property (
      !s_r.pin_dir[4] |=> s_r.pin_data[4] == $past(s_r.pin_data[4]))
      else $error("write reached an input pin bit");
   a_reserved: assert property (
      ra.rdata[7] == 1'b0 || ra.addr == ADDR_AN_FLAGS || ra.addr == ADDR_WB_CTRL ||
      ra.addr == ADDR_AN_MASK)
      else $error("reserved bit reads nonzero");
endmodule : fault_flags_and_port_regs

// *** test/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model
   import fault_regs_pkg::*;
(
   input  wire logic REF_CLK,
   input  wire logic MISO,
   output logic      CS_N,
   output logic      SCLK,
   output logic      MOSI
);
   initial begin
      CS_N = 1'b1;
      SCLK = 1'b0;
      MOSI = 1'b0;
   end
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction : crc8
   // Bad checksum or edge count only when asked for
   task automatic xfer(input logic [7:0] hdr, input logic [7:0] dat, input logic [7:0] cx,
                       input int edges, output logic [7:0] rd);
      logic [23:0] f;
      f = {hdr, dat, crc8({hdr, dat}) ^ cx};
      rd = 8'h00;
      @(posedge REF_CLK) CS_N <= 1'b0;
      for (int i = 0; i < edges; i++) begin
         MOSI <= (i < 24) ? f[23-i] : ~f[0];
         repeat (3) @(posedge REF_CLK);
         SCLK <= 1'b1;
         if (i >= 8 && i < 16) rd[15-i] = MISO;
         repeat (3) @(posedge REF_CLK);
         SCLK <= 1'b0;
      end
      repeat (3) @(posedge REF_CLK);
      CS_N <= 1'b1;
      MOSI <= ~MOSI;
      repeat (6) @(posedge REF_CLK);
   endtask : xfer
endmodule : spi_host_model

// *** test/fault_flags_and_port_regs_tb_top.sv ***
`timescale 1ns/1ps
module fault_flags_and_port_regs_tb_top;
   import fault_regs_pkg::*;
   logic       REF_CLK = 1'b0;
   logic       RST_N   = 1'b0;
   logic       cs_n, sclk, mosi, miso, gload, cstart;
   logic       cal, rom, hv, wbs, oovl, iovl, ovv, latch;
   logic [6:0] pin_in, pin_out, pin_oe, sw_drive;
   logic [7:0] wb_ctrl;
   int         n_fail = 0;
   int         checks = 0;
   int         cyc    = 0;
   always #2.5 REF_CLK = ~REF_CLK;
   spi_host_model i_spi_host_model (.REF_CLK(REF_CLK), .MISO(miso), .CS_N(cs_n), .SCLK(sclk),
      .MOSI(mosi));
   fault_flags_and_port_regs #(.INPUT_HOLD_CYCLES(16)) i_fault_flags_and_port_regs (
      .REF_CLK(REF_CLK), .RST_N(RST_N), .CS_N(cs_n), .SCLK(sclk), .MOSI(mosi), .MISO(miso),
      .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .CAL_ACTIVE(cal),
      .ROM_CHECK_FAIL(rom), .HV_SUPPLY_TRIP(hv), .WIRE_BREAK_SENSE(wbs),
      .OUTPUT_OVERLOAD(oovl), .INPUT_OVERLOAD(iovl), .SWITCH_OVERVOLT(ovv),
      .LATCHED_MODE(latch), .SWITCH_DRIVE(sw_drive), .WB_CONTROL(wb_ctrl),
      .GAIN_DEFAULT_LOAD(gload), .CAL_START(cstart));
   task automatic report_and_stop;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   // Generous ceiling; the run needs roughly 13300 cycles
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] r;
      i_spi_host_model.xfer({1'b0, a}, d, 8'h00, 24, r);
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] r;
      i_spi_host_model.xfer({1'b1, a}, 8'h00, 8'h00, 24, r);
      chk(r, exp);
   endtask : rd
   task automatic wait_pulse(ref logic s);
      for (int i = 0; i < 40 && s !== 1'b1; i++) @(negedge REF_CLK);
      chk({7'h00, s}, 8'h01);
   endtask : wait_pulse
   task automatic t_pins;
      chk({1'b0, sw_drive}, 8'h60);
      rd(ADDR_SW_SEL, 8'h60);
      wr(ADDR_PIN_DIR, 8'h0f);
      wr(ADDR_PIN_DATA, 8'hd5);
      chk({1'b0, pin_out}, 8'h05);
      chk({1'b0, pin_oe}, 8'h0f);
      pin_in <= 7'h2a;
      rd(ADDR_PIN_DATA, 8'h25);
   endtask : t_pins
   task automatic t_refuse;
      logic [7:0] hd[3] = '{8'h01, 8'h06, 8'h06};
      logic [7:0] cx[3] = '{8'h00, 8'h01, 8'h00};
      int         ed[3] = '{24, 24, 23};
      logic [7:0] ex[3] = '{8'h10, 8'h20, 8'h08};
      logic [7:0] r;
      for (int k = 0; k < 3; k++) begin
         i_spi_host_model.xfer(hd[k], 8'h12, cx[k], ed[k], r);
         rd(ADDR_IF_FLAGS, ex[k]);
         wr(ADDR_IF_FLAGS, 8'hff);
         rd(ADDR_IF_FLAGS, 8'h00);
      end
      rd(ADDR_SW_SEL, 8'h60);
   endtask : t_refuse
   task automatic t_analog;
      wr(ADDR_AN_FLAGS, 8'hff);
      wr(ADDR_AN_MASK, 8'h04);
      oovl <= 1'b1;
      @(posedge REF_CLK) oovl <= 1'b0;
      rd(ADDR_AN_FLAGS, 8'h04);
      iovl <= 1'b1;
      wait_pulse(gload);
      @(posedge REF_CLK) iovl <= 1'b0;
      wr(ADDR_SPECIAL_FUNCTION_CONFIG, 8'h03);
      cal <= 1'b1;
      rd(ADDR_AN_FLAGS, 8'h8e);
      chk({7'h00, pin_out[3]}, 8'h00);
      chk({7'h00, pin_out[2]}, 8'h01);
      wr(ADDR_IF_FLAGS, 8'hff);
      rd(ADDR_IF_FLAGS, 8'h40);
      wr(ADDR_AN_FLAGS, 8'h80);
      rd(ADDR_AN_FLAGS, 8'h0e);
   endtask : t_analog
   task automatic t_overvolt;
      for (int l = 0; l < 2; l++) begin
         latch <= l[0];
         wr(ADDR_AN_FLAGS, 8'hff);
         ovv <= 1'b1;
         @(posedge REF_CLK) ovv <= 1'b0;
         repeat (2) @(negedge REF_CLK);
         chk({1'b0, sw_drive}, 8'h00);
         rd(ADDR_SW_SEL, 8'h60);
         // Restore lands 4000 cycles after the trip; the first look comes just before it and the second just after, near cycles 3994 and 4004
         repeat (3840) @(negedge REF_CLK);
         chk({1'b0, sw_drive}, 8'h00);
         repeat (10) @(negedge REF_CLK);
         chk({1'b0, sw_drive}, 8'h60);
         rd(ADDR_AN_FLAGS, {7'h04, l[0]});
      end
   endtask : t_overvolt
   task automatic t_misc;
      wr(ADDR_AN_FLAGS, 8'hff);
      hv <= 1'b1;
      @(posedge REF_CLK) hv <= 1'b0;
      wait_pulse(cstart);
      wr(ADDR_WB_CTRL, 8'h0a);
      chk(wb_ctrl, 8'h0a);
      wbs <= 1'b1;
      rom <= 1'b1;
      rd(ADDR_AN_FLAGS, 8'h58);
      rd(ADDR_IF_FLAGS, 8'h41);
   endtask : t_misc
   initial begin
      {cal, rom, hv, wbs, oovl, iovl, ovv, latch} <= 8'h00;
      pin_in <= 7'h00;
      repeat (8) @(posedge REF_CLK);
      RST_N <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      t_pins();
      t_refuse();
      t_analog();
      t_overvolt();
      t_misc();
      report_and_stop();
   end
endmodule : fault_flags_and_port_regs_tb_top
